// ### dual_timer_params.svh
// Constants for the dual timer/counter block.
// Assumes inclusion by bare name; definitions only.
// Summary of operation
// - Counter one runs on run bit and gate.
// - Mode fields at bits 1:0 and 5:4.
// - Mode 0 is a 13-bit counter.
// - Low byte upper three bits stay outside carry.
// - Carries in modes 0-2 set overflow flags; counter one's carry does not while counter zero is in mode 3.
// - Counter one carry clocks the serial port.
// - Mode 1 is a full 16-bit counter.
// - Mode 2 reloads low byte from high byte.
// - Mode 3 low byte keeps counter zero controls.
// - Mode 3 high byte runs on run one.
// - Counter one in mode 3 holds.
// - Counter one still feeds serial clock.
// - Cascade bit chains both into 32 bits.
// - No auto-reload during soft power-down.
// - Leaving soft power-down with pin high adds one count.
// - Overflow is all-ones ANDed with clock.
// - Clock select picks divide-by-12 or pin.
// - Run bits four and six enable counters outside cascade.
// - Power-down routes pins past edge detector.
`ifndef DUAL_TIMER_PARAMS_SVH
`define DUAL_TIMER_PARAMS_SVH
`define IDX_TIMER_CONTROL  8'h88
`define IDX_TIMER_MODE     8'h89
`define IDX_C0_LOW         8'h8A
`define IDX_C1_LOW         8'h8B
`define IDX_C0_HIGH        8'h8C
`define IDX_C1_HIGH        8'h8D
`define IDX_POWER_CTL      8'h87
`define IDX_IO_CONTROL     8'hF8
`define C0_MODE_LO         0
`define C0_MODE_HI         1
`define C0_CLK_SEL         2
`define C0_GATE            3
`define C1_MODE_LO         4
`define C1_MODE_HI         5
`define C1_CLK_SEL         6
`define C1_GATE            7
`define RUN_ZERO_BIT       4
`define FLAG_ZERO_BIT      5
`define RUN_ONE_BIT        6
`define FLAG_ONE_BIT       7
`define CASCADE_BIT        6
`define SOFT_PD_BIT        0
`define HARD_PD_BIT        1
`define M13_LOW_MSB        4
`define RESET_BYTE         8'h00
`define PRESCALE_LAST      4'hB
`define S3_PHASE           4'h4
`define S5_PHASE           4'h8
`endif

// ### dual_timer_pkg.sv
// Types shared by the dual timer/counter files.
// Assumes no other package.
package dual_timer_pkg;
  // Counting modes selected by a two-bit field.
  typedef enum logic [1:0] {MODE_13BIT, MODE_16BIT, MODE_RELOAD8, MODE_SPLIT} count_mode_e;
endpackage

// ### count_strobe_if.sv
// Carrier between the timer core and one count-pin edge detector.
// Assumes both ends run on pclk.
`timescale 1ns/10ps
interface count_strobe_if;
  logic count_pin;   // Raw count pin level.
  logic s3_strobe;   // Internal count phase.
  logic s5_strobe;   // Detector transfer phase.
  logic power_down;  // Soft or hard power-down.
  logic soft_down;   // Soft power-down alone.
  logic count_tick;  // One-cycle qualified count.
  modport detector (input count_pin, s3_strobe, s5_strobe, power_down, soft_down,
                    output count_tick);
  modport timer (output count_pin, s3_strobe, s5_strobe, power_down, soft_down,
                 input count_tick);
endinterface

// ### count_edge_detector.sv
// Falling-edge detector for one external count pin.
// Assumes the pin is synchronous to pclk.
`timescale 1ns/10ps
module count_edge_detector (
  input wire logic           pclk,
  input wire logic           presetn,
  count_strobe_if.detector   strb
);
  logic pin_q_reg;   // Pin level one cycle back.
  logic caught_reg;  // Edge caught, waiting for transfer.
  logic passed_reg;  // Edge passed at S5.
  logic soft_q_reg;  // Soft power-down one cycle back.
  wire  fall_edge  = pin_q_reg & ~strb.count_pin;
  wire  norm_tick  = passed_reg & caught_reg & strb.s3_strobe;
  // Leaving soft power-down with the pin high adds a count.
  wire  exit_tick  = soft_q_reg & ~strb.soft_down & strb.count_pin;
  // In power-down the pin edge goes straight to the counter.
  assign strb.count_tick = strb.power_down ? fall_edge : (norm_tick | exit_tick);

  // Edge capture; a new edge wins over the clear by the tick.
  // An edge already counted directly in power-down is not latched, so it cannot count twice.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q_reg  <= 1'b0;
      caught_reg <= 1'b0;
      passed_reg <= 1'b0;
      soft_q_reg <= 1'b0;
    end else begin
      pin_q_reg  <= strb.count_pin;
      soft_q_reg <= strb.soft_down;
      caught_reg <= (fall_edge & ~strb.power_down) | (caught_reg & ~norm_tick);
      if (strb.s5_strobe) begin
        passed_reg <= caught_reg;
      end
    end
  end
endmodule

// ### dual_timer_counter.sv
// Two up-counting timer/counters with four modes and a 32-bit cascade.
// Assumes an APB master on pclk and count/gate pins synchronous to pclk.
`timescale 1ns/10ps
`include "dual_timer_params.svh"
module dual_timer_counter #(
  parameter int ADDR_W = 12
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              count_pin_zero,
  input  wire logic              count_pin_one,
  input  wire logic              gate_input_zero,
  input  wire logic              gate_input_one,
  output logic                   overflow_flag_zero,
  output logic                   overflow_flag_one,
  output logic                   serial_clk_pulse,
  output logic                   wake_request
);
  // Register state.
  logic [7:0]  timer_mode_select_reg; // Mode, clock select and gate bits.
  logic [7:0]  c0_low_reg;            // Counter zero low byte.
  logic [7:0]  c0_high_reg;           // Counter zero high byte.
  logic [7:0]  c1_low_reg;            // Counter one low byte.
  logic [7:0]  c1_high_reg;           // Counter one high byte.
  logic        run_ctl_zero_reg;      // Run bit of counter zero.
  logic        run_ctl_one_reg;       // Run bit of counter one.
  logic        flag0_reg;             // Overflow flag zero.
  logic        flag1_reg;             // Overflow flag one.
  logic        cascade_enable_reg;    // 32-bit chaining.
  logic        soft_pd_reg;           // Soft power-down.
  logic        hard_pd_reg;           // Hard power-down.
  logic [3:0]  presc_reg;             // Divide-by-12 phase.
  logic [31:0] prdata_reg;            // Read data.
  logic        pready_reg;            // Access completes.
  logic        pslverr_reg;           // Unmapped access.
  logic        serial_reg;            // Serial port clock pulse.
  logic        wake_reg;              // Wake pulse on overflow in power-down.

  // Next values from the counting logic.
  logic [7:0]  c0_low_next;
  logic [7:0]  c0_high_next;
  logic [7:0]  c1_low_next;
  logic [7:0]  c1_high_next;
  logic        carry0;
  logic        carry1;
  logic        carry_split;
  logic        carry32;

  // One counting step; returns carry, high byte and low byte.
  function automatic logic [16:0] count_step(input dual_timer_pkg::count_mode_e mode,
                                             input logic [7:0] hi,
                                             input logic [7:0] lo,
                                             input logic reload_ok);
    logic [8:0]  lo_sum;
    logic [8:0]  hi_sum;
    logic [16:0] res;
    lo_sum = {1'b0, lo} + 9'h001;
    hi_sum = {1'b0, hi} + 9'h001;
    case (mode)
      // Only five low bits feed the high byte; the upper three still count.
      dual_timer_pkg::MODE_13BIT: begin
        res = (&lo[`M13_LOW_MSB:0]) ? {hi_sum, lo_sum[7:0]} : {1'b0, hi, lo_sum[7:0]};
      end
      dual_timer_pkg::MODE_16BIT: begin
        res = (&lo) ? {hi_sum, lo_sum[7:0]} : {1'b0, hi, lo_sum[7:0]};
      end
      // Reload from the high byte unless in soft power-down.
      dual_timer_pkg::MODE_RELOAD8: begin
        res = (&lo) ? {1'b1, hi, (reload_ok ? hi : `RESET_BYTE)} : {1'b0, hi, lo_sum[7:0]};
      end
      default: begin
        res = {lo_sum[8], hi, lo_sum[7:0]};
      end
    endcase
    return res;
  endfunction

  // Mode decoding.
  wire dual_timer_pkg::count_mode_e mode0 =
    dual_timer_pkg::count_mode_e'(timer_mode_select_reg[`C0_MODE_HI:`C0_MODE_LO]);
  wire dual_timer_pkg::count_mode_e mode1 =
    dual_timer_pkg::count_mode_e'(timer_mode_select_reg[`C1_MODE_HI:`C1_MODE_LO]);
  wire split0 = (mode0 == dual_timer_pkg::MODE_SPLIT);
  wire hold1  = (mode1 == dual_timer_pkg::MODE_SPLIT);

  // Internal clock phases stop while in power-down.
  wire pd_any   = soft_pd_reg | hard_pd_reg;
  wire s3_phase = (presc_reg == `S3_PHASE) & ~pd_any;
  wire s5_phase = (presc_reg == `S5_PHASE) & ~pd_any;

  // Edge detectors for the two count pins.
  count_strobe_if strobe0_if ();
  count_strobe_if strobe1_if ();
  assign strobe0_if.count_pin  = count_pin_zero;
  assign strobe0_if.s3_strobe  = s3_phase;
  assign strobe0_if.s5_strobe  = s5_phase;
  assign strobe0_if.power_down = pd_any;
  assign strobe0_if.soft_down  = soft_pd_reg;
  assign strobe1_if.count_pin  = count_pin_one;
  assign strobe1_if.s3_strobe  = s3_phase;
  assign strobe1_if.s5_strobe  = s5_phase;
  assign strobe1_if.power_down = pd_any;
  assign strobe1_if.soft_down  = soft_pd_reg;

  count_edge_detector det0 (
    .pclk    (pclk),
    .presetn (presetn),
    .strb    (strobe0_if)
  );
  count_edge_detector det1 (
    .pclk    (pclk),
    .presetn (presetn),
    .strb    (strobe1_if)
  );

  // Clock source selection per counter.
  wire tick0 = timer_mode_select_reg[`C0_CLK_SEL] ? strobe0_if.count_tick : s3_phase;
  wire tick1 = timer_mode_select_reg[`C1_CLK_SEL] ? strobe1_if.count_tick : s3_phase;

  // Run gating by run bit and, when enabled, by the gate pin.
  wire run0 = run_ctl_zero_reg &
              (~timer_mode_select_reg[`C0_GATE] | gate_input_zero);
  wire run1 = run_ctl_one_reg &
              (~timer_mode_select_reg[`C1_GATE] | gate_input_one);

  // Counting steps.
  wire [16:0] step0 = count_step(mode0, c0_high_reg, c0_low_reg, ~soft_pd_reg);
  wire [16:0] step1 = count_step(mode1, c1_high_reg, c1_low_reg, ~soft_pd_reg);
  wire [8:0]  split_sum = {1'b0, c0_high_reg} + 9'h001;
  wire [32:0] chain_sum = {1'b0, c1_high_reg, c1_low_reg, c0_high_reg, c0_low_reg} + 33'h000000001;

  // APB decoding.
  wire       access   = psel & penable;
  wire       first    = access & ~pready_reg;
  wire       wr_fire  = access & pwrite & pready_reg;
  wire [7:0] reg_idx  = paddr[9:2];
  wire       aligned  = (paddr[1:0] == 2'b00) & (paddr[ADDR_W-1:10] == '0);
  wire       hit_ctl  = aligned & (reg_idx == `IDX_TIMER_CONTROL);
  wire       hit_mode = aligned & (reg_idx == `IDX_TIMER_MODE);
  wire       hit_c0l  = aligned & (reg_idx == `IDX_C0_LOW);
  wire       hit_c1l  = aligned & (reg_idx == `IDX_C1_LOW);
  wire       hit_c0h  = aligned & (reg_idx == `IDX_C0_HIGH);
  wire       hit_c1h  = aligned & (reg_idx == `IDX_C1_HIGH);
  wire       hit_pwr  = aligned & (reg_idx == `IDX_POWER_CTL);
  wire       hit_io   = aligned & (reg_idx == `IDX_IO_CONTROL);
  wire       hit_any  = hit_ctl | hit_mode | hit_c0l | hit_c1l | hit_c0h | hit_c1h |
                        hit_pwr | hit_io;
  wire [7:0] ctl_view = {flag1_reg, run_ctl_one_reg, flag0_reg, run_ctl_zero_reg, 4'h0};
  wire [7:0] rd_byte  = hit_ctl  ? ctl_view :
                        hit_mode ? timer_mode_select_reg :
                        hit_c0l  ? c0_low_reg :
                        hit_c1l  ? c1_low_reg :
                        hit_c0h  ? c0_high_reg :
                        hit_c1h  ? c1_high_reg :
                        hit_pwr  ? {6'h00, hard_pd_reg, soft_pd_reg} :
                        hit_io   ? {1'b0, cascade_enable_reg, 6'h00} : `RESET_BYTE;

  // Counter next values; a software write to a byte wins over counting.
  always_comb begin
    c0_low_next  = c0_low_reg;
    c0_high_next = c0_high_reg;
    c1_low_next  = c1_low_reg;
    c1_high_next = c1_high_reg;
    carry0       = 1'b0;
    carry1       = 1'b0;
    carry_split  = 1'b0;
    carry32      = 1'b0;
    if (cascade_enable_reg) begin
      // Both counters form one 32-bit counter on counter zero's clock.
      if (tick0) begin
        {c1_high_next, c1_low_next, c0_high_next, c0_low_next} = chain_sum[31:0];
        carry32 = chain_sum[32];
      end
    end else begin
      // Counter zero, or its low byte alone in split mode.
      if (run0 && tick0) begin
        c0_low_next = step0[7:0];
        carry0      = step0[16];
        if (!split0) begin
          c0_high_next = step0[15:8];
        end
      end
      // Split high byte counts the internal clock under run one only.
      if (split0 && run_ctl_one_reg && s3_phase) begin
        c0_high_next = split_sum[7:0];
        carry_split  = split_sum[8];
      end
      // Counter one holds in mode 3.
      if (!hold1 && run1 && tick1) begin
        {c1_high_next, c1_low_next} = step1[15:0];
        carry1 = step1[16];
      end
    end
    if (wr_fire && hit_c0l) begin
      c0_low_next = pwdata[7:0];
    end
    if (wr_fire && hit_c0h) begin
      c0_high_next = pwdata[7:0];
    end
    if (wr_fire && hit_c1l) begin
      c1_low_next = pwdata[7:0];
    end
    if (wr_fire && hit_c1h) begin
      c1_high_next = pwdata[7:0];
    end
  end

  // Flag set terms; counter one's carry is ignored while counter zero is split.
  wire set0  = carry0;
  wire set1  = (carry1 & ~split0) | carry_split | carry32;
  wire wrctl = wr_fire & hit_ctl;

  // Counter byte storage.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c0_low_reg  <= `RESET_BYTE;
      c0_high_reg <= `RESET_BYTE;
      c1_low_reg  <= `RESET_BYTE;
      c1_high_reg <= `RESET_BYTE;
    end else begin
      c0_low_reg  <= c0_low_next;
      c0_high_reg <= c0_high_next;
      c1_low_reg  <= c1_low_next;
      c1_high_reg <= c1_high_next;
    end
  end

  // Control bits; hardware set wins over a software clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_mode_select_reg <= `RESET_BYTE;
      run_ctl_zero_reg      <= 1'b0;
      run_ctl_one_reg       <= 1'b0;
      flag0_reg             <= 1'b0;
      flag1_reg             <= 1'b0;
      cascade_enable_reg    <= 1'b0;
    end else begin
      if (wr_fire && hit_mode) begin
        timer_mode_select_reg <= pwdata[7:0];
      end
      if (wrctl) begin
        run_ctl_zero_reg <= pwdata[`RUN_ZERO_BIT];
        run_ctl_one_reg  <= pwdata[`RUN_ONE_BIT];
      end
      if (wr_fire && hit_io) begin
        cascade_enable_reg <= pwdata[`CASCADE_BIT];
      end
      flag0_reg <= set0 | (wrctl ? pwdata[`FLAG_ZERO_BIT] : flag0_reg);
      flag1_reg <= set1 | (wrctl ? pwdata[`FLAG_ONE_BIT] : flag1_reg);
    end
  end

  // Power-down state, left on any flag-setting overflow while down, and the prescaler.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_pd_reg <= 1'b0;
      hard_pd_reg <= 1'b0;
      wake_reg    <= 1'b0;
      presc_reg   <= 4'h0;
    end else begin
      wake_reg <= pd_any & (set0 | set1);
      if (pd_any && (set0 || set1)) begin
        soft_pd_reg <= 1'b0;
        hard_pd_reg <= 1'b0;
      end else if (wr_fire && hit_pwr) begin
        soft_pd_reg <= pwdata[`SOFT_PD_BIT];
        hard_pd_reg <= pwdata[`HARD_PD_BIT];
      end
      if (pd_any || presc_reg == `PRESCALE_LAST) begin
        presc_reg <= 4'h0;
      end else begin
        presc_reg <= presc_reg + 4'h1;
      end
    end
  end

  // APB slave with one wait state so that read data comes from a register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
      serial_reg  <= 1'b0;
    end else begin
      pready_reg  <= first;
      pslverr_reg <= first & ~hit_any;
      if (first) begin
        prdata_reg <= {24'h000000, rd_byte};
      end
      serial_reg <= carry1;
    end
  end

  assign prdata             = prdata_reg;
  assign pready             = pready_reg;
  assign pslverr            = pslverr_reg;
  assign overflow_flag_zero = flag0_reg;
  assign overflow_flag_one  = flag1_reg;
  assign serial_clk_pulse   = serial_reg;
  assign wake_request       = wake_reg;
endmodule

// ### dual_timer_counter_sva.sv
// Checker for the dual timer/counter: bus handshake, flags and pulses.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/10ps
module dual_timer_counter_sva #(
  parameter int ADDR_W = 12
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              overflow_flag_zero,
  input wire logic              overflow_flag_one,
  input wire logic              serial_clk_pulse,
  input wire logic              wake_request
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A write that completed without error, and one to the control register.
  wire        done_wr = psel & penable & pready & pwrite & ~pslverr;
  wire        ctl_wr  = done_wr & (paddr == ADDR_W'(12'h220));
  logic [1:0] c0_mode_reg;  // Counter zero mode as last written.
  // Track the mode field so that carries of counter one can be judged.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) c0_mode_reg <= 2'h0;
    else if (done_wr & (paddr == ADDR_W'(12'h224))) c0_mode_reg <= pwdata[1:0];
  end
  // A setup cycle, then one wait state before the answer.
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence answer_s;
    !pready ##1 pready;
  endsequence
  a_setup_one_wait: assert property (setup_s |=> answer_s)
    else $error("Bus answer not after exactly one wait state");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("Ready outside an access phase");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("Ready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("Error response without ready");
  a_bad_addr_err: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("Misaligned access not refused");
  a_read_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
    else $error("Read data upper bits not zero");
  // The carry behind a pulse was judged against the mode one cycle before the pulse.
  a_serial_sets_flag: assert property (
    serial_clk_pulse && $past(c0_mode_reg) != 2'h3 |-> overflow_flag_one)
    else $error("Counter one carry did not set its flag");
  a_serial_single: assert property (serial_clk_pulse |=> !serial_clk_pulse)
    else $error("Serial clock pulse longer than one cycle");
  a_flag_only_sw: assert property (
    $fell(overflow_flag_zero) || $fell(overflow_flag_one) |-> $past(ctl_wr))
    else $error("Overflow flag cleared without a control write");
  a_wake_single: assert property (wake_request |=> !wake_request)
    else $error("Wake request longer than one cycle");
endmodule
bind dual_timer_counter dual_timer_counter_sva #(.ADDR_W(ADDR_W)) u_sva (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .overflow_flag_zero, .overflow_flag_one, .serial_clk_pulse, .wake_request);

// ### count_pin_model.sv
// Model of the external parties that drive the two count pins.
// Assumes the pins are sampled on pclk; idle pins rest low.
`timescale 1ns/10ps
module count_pin_model #(
  parameter int HALF = 12
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic run_zero,
  input  wire logic run_one,
  output logic      pin_zero,
  output logic      pin_one
);
  logic [4:0] cnt_reg;  // Cycles spent at the present level.
  // Each level lasts HALF cycles; a stopped pin falls and stays low.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg  <= 5'h00;
      pin_zero <= 1'b0;
      pin_one  <= 1'b0;
    end else if (cnt_reg == 5'(HALF - 1)) begin
      cnt_reg  <= 5'h00;
      pin_zero <= run_zero & ~pin_zero;
      pin_one  <= run_one & ~pin_one;
    end else begin
      cnt_reg <= cnt_reg + 5'h01;
    end
  end
endmodule

// ### dual_timer_counter_modes_tb_top.sv
// Self-checking bench for the dual timer/counter over APB with a count pin model.
// Assumes the design, its checker and the pin model are compiled before it.
`timescale 1ns/10ps
module dual_timer_counter_modes_tb_top;
  // One overflow case of counter zero: setup, read mask and expected bytes.
  typedef struct {
    logic [7:0] mode;
    logic [7:0] lo;
    logic [7:0] hi;
    logic [7:0] mask;
    logic [7:0] exp_lo;
    logic [7:0] exp_hi;
  } ovf_row_s;
  logic        pclk            = 1'b0;  // 40 MHz bus clock.
  logic        presetn         = 1'b0;  // Held low from time zero.
  logic        psel            = 1'b0;
  logic        penable         = 1'b0;
  logic        pwrite          = 1'b0;
  logic [11:0] paddr           = 12'h000;
  logic [31:0] pwdata          = 32'h0000_0000;
  logic        gate_input_zero = 1'b0;
  logic        gate_input_one  = 1'b0;
  logic        run_pin_zero    = 1'b0;  // Asks the pin model for pulses.
  logic        run_pin_one     = 1'b0;
  logic [31:0] prdata, rdv;
  logic        pready, pslverr, erv, count_pin_zero, count_pin_one;
  logic        overflow_flag_zero, overflow_flag_one, serial_clk_pulse, wake_request;
  int          err_total, check_count, ser_cnt, wake_cnt, mark;
  ovf_row_s    rows [4] = '{
    '{8'h01, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00},
    '{8'h00, 8'h1F, 8'hFF, 8'h1F, 8'h00, 8'h00},
    '{8'h02, 8'hFF, 8'hA5, 8'hFF, 8'hA5, 8'hA5},
    '{8'h03, 8'hFF, 8'h33, 8'hFF, 8'h00, 8'h33}};
  dual_timer_counter u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .count_pin_zero, .count_pin_one, .gate_input_zero,
    .gate_input_one, .overflow_flag_zero, .overflow_flag_one, .serial_clk_pulse,
    .wake_request);
  count_pin_model u_pins (.pclk, .presetn, .run_zero(run_pin_zero), .run_one(run_pin_one),
    .pin_zero(count_pin_zero), .pin_one(count_pin_one));
  always #12.5 pclk = ~pclk;
  // Count one-cycle pulses so that waits cannot miss them.
  always @(posedge pclk) begin
    if (serial_clk_pulse === 1'b1) ser_cnt <= ser_cnt + 1;
    if (wake_request === 1'b1) wake_cnt <= wake_cnt + 1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; the request holds until ready is sampled high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h000000, d});
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdv & {24'h000000, m}, {24'h000000, e});
  endtask
  // Waits a bounded time for an overflow flag, then checks it.
  task automatic wait_flag(input logic one);
    for (int i = 0; i < 40 && (one ? overflow_flag_one : overflow_flag_zero) !== 1'b1; i++)
      @(posedge pclk);
    chk(one ? overflow_flag_one : overflow_flag_zero, 32'h1);
  endtask
  task automatic end_test(input string name);
    $display("Test %s done", name);
  endtask
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Main sequence: register checks, table of overflow cases, then hand-written cases.
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(12'h224, 8'h00, 8'hFF);
    wr(12'h224, 8'hA5);
    rdchk(12'h224, 8'hA5, 8'hFF);
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk(erv, 32'h1);
    chk(rdv, 32'h0);
    apb(1'b1, 12'h225, 32'h0000_0011);
    chk(erv, 32'h1);
    rdchk(12'h224, 8'hA5, 8'hFF);
    end_test("registers");
    foreach (rows[i]) begin
      wr(12'h224, rows[i].mode);
      wr(12'h228, rows[i].lo);
      wr(12'h230, rows[i].hi);
      wr(12'h220, 8'h10);
      wait_flag(1'b0);
      wr(12'h220, 8'h20);
      rdchk(12'h228, rows[i].exp_lo, rows[i].mask);
      rdchk(12'h230, rows[i].exp_hi, 8'hFF);
      wr(12'h220, 8'h00);
      // The clear lands at the write's last edge, so the flag is looked at one edge on.
      @(posedge pclk);
      chk(overflow_flag_zero, 32'h0);
      end_test("overflow row");
    end
    wr(12'h224, 8'h33);
    wr(12'h22C, 8'hFF);
    wr(12'h234, 8'hFF);
    wr(12'h230, 8'hFF);
    wr(12'h220, 8'h40);
    wait_flag(1'b1);
    wr(12'h220, 8'h80);
    rdchk(12'h22C, 8'hFF, 8'hFF);
    rdchk(12'h230, 8'h00, 8'hFF);
    wr(12'h224, 8'h23);
    wr(12'h22C, 8'hFE);
    wr(12'h234, 8'hFE);
    mark = ser_cnt;
    wr(12'h220, 8'h40);
    repeat (40) @(posedge pclk);
    chk(ser_cnt > mark, 32'h1);
    chk(overflow_flag_one, 32'h0);
    end_test("split mode");
    wr(12'h224, 8'h80);
    wr(12'h22C, 8'h1F);
    wr(12'h234, 8'hFF);
    mark = ser_cnt;
    repeat (40) @(posedge pclk);
    chk(overflow_flag_one, 32'h0);
    gate_input_one <= 1'b1;
    wait_flag(1'b1);
    repeat (2) @(posedge pclk);
    chk(ser_cnt > mark, 32'h1);
    wr(12'h220, 8'h00);
    end_test("gate");
    wr(12'h224, 8'h05);
    wr(12'h228, 8'hFF);
    wr(12'h230, 8'hFF);
    wr(12'h220, 8'h10);
    wr(12'h21C, 8'h01);
    mark = wake_cnt;
    run_pin_zero <= 1'b1;
    for (int i = 0; i < 80 && wake_cnt == mark; i++) @(posedge pclk);
    run_pin_zero <= 1'b0;
    chk(wake_cnt > mark, 32'h1);
    chk(overflow_flag_zero, 32'h1);
    rdchk(12'h21C, 8'h00, 8'hFF);
    rdchk(12'h228, 8'h00, 8'hFF);
    // Software clears the count after a wake so that no stray count lingers.
    wr(12'h228, 8'h00);
    wr(12'h220, 8'h00);
    end_test("power down");
    wr(12'h224, 8'h00);
    foreach (rows[i]) wr(12'h228 + 12'(4 * i), 8'hFF);
    wr(12'h3E0, 8'h40);
    wait_flag(1'b1);
    wr(12'h3E0, 8'h00);
    wr(12'h220, 8'h10);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({pready, pslverr, overflow_flag_zero, overflow_flag_one, serial_clk_pulse,
         wake_request}, 32'h0);
    presetn <= 1'b1;
    rdchk(12'h220, 8'h00, 8'hFF);
    rdchk(12'h224, 8'h00, 8'hFF);
    end_test("cascade and reset");
    close_out();
  end
  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    close_out();
  end
endmodule
